// ---- logic/cliu_consts.svh ----
`ifndef CLIU_CONSTS_SVH
`define CLIU_CONSTS_SVH
// Register byte offsets
`define CLIU_OFF_CTRL   8'h00
`define CLIU_OFF_STAT   8'h04
`define CLIU_OFF_AF     8'h08
`define CLIU_OFF_PAIR1  8'h0c
`define CLIU_OFF_PAIR2  8'h10
`define CLIU_OFF_PAIR3  8'h14
`define CLIU_OFF_STKP   8'h18
`define CLIU_OFF_IDXX   8'h1c
`define CLIU_OFF_IDXY   8'h20
`define CLIU_OFF_PC     8'h24
`define CLIU_OFF_IR     8'h28
`define CLIU_LAST_IDX   6'd10
// Field positions
`define CLIU_CTRL_RUN   0
`define CLIU_ST_BUSY    0
`define CLIU_ST_ILL     1
`define CLIU_IR_SHADOW  16
`define CLIU_F_S        7
`define CLIU_F_Z        6
`define CLIU_F_H        4
`define CLIU_F_PV       2
`define CLIU_F_N        1
`define CLIU_F_C        0
// Reset values
`define CLIU_PC_RST     16'h0000
`define CLIU_WORD_RST   16'h0000
// Clock states per machine cycle
`define CLIU_T_M1       3'd4
`define CLIU_T_MEM      3'd3
`define CLIU_T_IDX      3'd5
`define CLIU_T_XTRA     3'd1
// Whole-instruction clock states
`define CLIU_TOT_SPEC   5'd9
`define CLIU_TOT_ST     5'd7
`define CLIU_TOT_IMM    5'd10
`define CLIU_TOT_IMMX   5'd14
`define CLIU_TOT_LDHL   5'd16
`define CLIU_TOT_IND    5'd20
`define CLIU_TOT_STX    5'd19
// Opcodes
`define CLIU_OP_ED      8'hed
`define CLIU_OP_PFXX    8'hdd
`define CLIU_OP_PFXY    8'hfd
`define CLIU_OP_A_VEC   8'h57
`define CLIU_OP_A_REF   8'h5f
`define CLIU_OP_VEC_A   8'h47
`endif

// ---- logic/cliu_pkg.sv ----
package cliu_pkg;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FETCH = 3'b010,
		S_EXEC  = 3'b100
	} cliu_state_t;
	typedef enum logic [2:0] {
		C_SPEC, C_IMM16, C_IND16, C_STREG, C_STN, C_STXN, C_STXR
	} cliu_cls_t;
	typedef enum logic [1:0] {K_OPR, K_MRD, K_WR, K_INT} cliu_kind_t;
	typedef enum logic [1:0] {P_NONE, P_ED, P_IDXX, P_IDXY} cliu_pfx_t;
endpackage

// ---- logic/cliu_top.sv ----
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "cliu_consts.svh"
module cliu_top #(
	parameter int AW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// AXI4-Lite slave
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// External memory
	output logic [15:0]        mem_addr,
	output logic               mem_rd,
	output logic               mem_wr,
	output logic [7:0]         mem_wdata,
	input  wire logic [7:0]    mem_rdata
);
	import cliu_pkg::*;

	// Core state
	cliu_state_t st_reg, st_next;
	cliu_pfx_t   pfx_reg, pfx_next;
	cliu_cls_t   cls_reg, cls_next;
	logic [7:0]  op_reg, op_next;
	logic [2:0]  tgt_reg, tgt_next, src_reg, src_next, tc_reg, tc_next;
	logic [1:0]  step_reg, step_next;
	logic [15:0] adr_reg, adr_next;
	logic [7:0]  dat_reg, dat_next;
	logic [7:0]  gp_reg [0:7];
	logic [7:0]  gp_next [0:7];
	logic [15:0] wd_reg [0:3];
	logic [15:0] wd_next [0:3];
	logic [7:0]  i_reg, i_next, r_reg, r_next;
	logic        iff_reg, iff_next, run_reg, run_next, ill_reg, ill_next;
	logic [4:0]  itc_reg, itc_next, last_reg, last_next;
	logic [15:0] maddr_reg, maddr_next;
	logic        mrd_reg, mrd_next, mwr_reg, mwr_next;
	logic [7:0]  mwd_reg, mwd_next;
	// Core temporaries
	logic [4:0]  si, sn;
	cliu_kind_t  kind, kn;
	logic        tend, ok, done, flag_upd, w16_en;
	logic [15:0] w16_val;
	logic [7:0]  v;
	logic [31:0] wmerged;
	// Bus state
	logic          awr_reg, awr_next, awf_reg, awf_next, wr_reg, wr_next, wf_reg, wf_next;
	logic [AW-1:0] awa_reg, awa_next;
	logic [31:0]   wdat_reg, wdat_next, rdat_reg, rdat_next;
	logic [3:0]    wstb_reg, wstb_next;
	logic          bv_reg, bv_next, arr_reg, arr_next, rv_reg, rv_next;
	logic [1:0]    bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic          wfire;

	// Kind and length of each machine cycle after the opcode fetch
	function automatic logic [4:0] step_info(cliu_cls_t c, logic [1:0] s);
		case (c)
			C_SPEC:  return {K_INT, `CLIU_T_XTRA};
			C_IMM16: return {K_OPR, `CLIU_T_MEM};
			C_IND16: return (s < 2'd2) ? {K_OPR, `CLIU_T_MEM} : {K_MRD, `CLIU_T_MEM};
			C_STREG: return {K_WR, `CLIU_T_MEM};
			C_STN:   return (s == 2'd0) ? {K_OPR, `CLIU_T_MEM} : {K_WR, `CLIU_T_MEM};
			C_STXN:  return (s == 2'd0) ? {K_OPR, `CLIU_T_MEM} :
				(s == 2'd1) ? {K_OPR, `CLIU_T_IDX} : {K_WR, `CLIU_T_MEM};
			C_STXR:  return (s == 2'd0) ? {K_OPR, `CLIU_T_MEM} :
				(s == 2'd1) ? {K_INT, `CLIU_T_IDX} : {K_WR, `CLIU_T_MEM};
			default: return {K_INT, `CLIU_T_XTRA};
		endcase
	endfunction

	function automatic logic [1:0] last_step(cliu_cls_t c);
		case (c)
			C_IMM16, C_STN:  return 2'd1;
			C_IND16:         return 2'd3;
			C_STXN, C_STXR:  return 2'd2;
			default:         return 2'd0;
		endcase
	endfunction

	function automatic logic [15:0] pair16(logic [1:0] p);
		return {gp_reg[{p, 1'b0}], gp_reg[{p, 1'b1}]};
	endfunction

	function automatic logic map_hit(logic [AW-1:0] a);
		return a[7:2] <= `CLIU_LAST_IDX;
	endfunction

	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				o[k*8 +: 8] = n[k*8 +: 8];
			end
		end
		return o;
	endfunction

	// Register view seen by software
	function automatic logic [31:0] rd_word(logic [AW-1:0] a);
		case ({a[7:2], 2'b00})
			`CLIU_OFF_CTRL: return {31'h0, run_reg};
			`CLIU_OFF_STAT: return {3'h0, last_reg, op_reg, 14'h0, ill_reg, st_reg != S_IDLE};
			`CLIU_OFF_AF:   return {16'h0, gp_reg[7], gp_reg[6]};
			`CLIU_OFF_PAIR1: return {16'h0, pair16(2'd0)};
			`CLIU_OFF_PAIR2: return {16'h0, pair16(2'd1)};
			`CLIU_OFF_PAIR3: return {16'h0, pair16(2'd2)};
			`CLIU_OFF_STKP: return {16'h0, wd_reg[0]};
			`CLIU_OFF_IDXX: return {16'h0, wd_reg[1]};
			`CLIU_OFF_IDXY: return {16'h0, wd_reg[2]};
			`CLIU_OFF_PC:   return {16'h0, wd_reg[3]};
			`CLIU_OFF_IR:   return {15'h0, iff_reg, i_reg, r_reg};
			default:        return 32'h0;
		endcase
	endfunction

	assign wfire = awf_reg & wf_reg & ~bv_reg;

	// Fetch, decode and execute; software writes land here too
	always_comb begin
		st_next = st_reg;
		pfx_next = pfx_reg;
		cls_next = cls_reg;
		op_next = op_reg;
		tgt_next = tgt_reg;
		src_next = src_reg;
		step_next = step_reg;
		tc_next = tc_reg + 3'd1;
		adr_next = adr_reg;
		dat_next = dat_reg;
		gp_next = gp_reg;
		wd_next = wd_reg;
		i_next = i_reg;
		r_next = r_reg;
		iff_next = iff_reg;
		run_next = run_reg;
		ill_next = ill_reg;
		itc_next = itc_reg + 5'd1;
		last_next = last_reg;
		done = 1'b0;
		ok = 1'b1;
		flag_upd = 1'b0;
		w16_en = 1'b0;
		w16_val = 16'h0;
		v = 8'h0;
		si = step_info(cls_reg, step_reg);
		kind = cliu_kind_t'(si[4:3]);
		tend = (st_reg == S_FETCH) ? (tc_reg == `CLIU_T_M1 - 3'd1) : (tc_reg == si[2:0] - 3'd1);
		wmerged = merge(rd_word(awa_reg), wdat_reg, wstb_reg);
		// Clear before the core so a same-cycle error still sets
		if (wfire) begin
			case ({awa_reg[7:2], 2'b00})
				`CLIU_OFF_CTRL: run_next = wmerged[`CLIU_CTRL_RUN];
				`CLIU_OFF_STAT: if (wmerged[`CLIU_ST_ILL]) ill_next = 1'b0;
				default: ;
			endcase
			// Software writes to architectural registers only land while the core is idle
			if (st_reg == S_IDLE) begin
				case ({awa_reg[7:2], 2'b00})
					`CLIU_OFF_AF: {gp_next[7], gp_next[6]} = wmerged[15:0];
					`CLIU_OFF_PAIR1: {gp_next[0], gp_next[1]} = wmerged[15:0];
					`CLIU_OFF_PAIR2: {gp_next[2], gp_next[3]} = wmerged[15:0];
					`CLIU_OFF_PAIR3: {gp_next[4], gp_next[5]} = wmerged[15:0];
					`CLIU_OFF_STKP: wd_next[0] = wmerged[15:0];
					`CLIU_OFF_IDXX: wd_next[1] = wmerged[15:0];
					`CLIU_OFF_IDXY: wd_next[2] = wmerged[15:0];
					`CLIU_OFF_PC: wd_next[3] = wmerged[15:0];
					`CLIU_OFF_IR: {iff_next, i_next, r_next} = wmerged[16:0];
					default: ;
				endcase
			end
		end
		case (st_reg)
			S_IDLE: begin
				tc_next = 3'd0;
				itc_next = 5'd0;
				if (run_reg) st_next = S_FETCH;
			end
			S_FETCH: if (tend) begin
				tc_next = 3'd0;
				step_next = 2'd0;
				op_next = mem_rdata;
				wd_next[3] = wd_reg[3] + 16'd1;
				r_next[6:0] = r_reg[6:0] + 7'd1; // Bit 7 of the refresh counter is kept
				st_next = S_EXEC;
				src_next = 3'd7;
				// A DD or FD prefix byte picks the index register; the rest is shared
				if (pfx_reg == P_NONE && mem_rdata == `CLIU_OP_ED) begin
					pfx_next = P_ED;
					st_next = S_FETCH;
				end else if (pfx_reg == P_NONE && mem_rdata == `CLIU_OP_PFXX) begin
					pfx_next = P_IDXX;
					st_next = S_FETCH;
				end else if (pfx_reg == P_NONE && mem_rdata == `CLIU_OP_PFXY) begin
					pfx_next = P_IDXY;
					st_next = S_FETCH;
				end else begin
					case (pfx_reg)
						P_NONE: casez (mem_rdata)
							8'h02, 8'h12: begin
								cls_next = C_STREG;
								adr_next = pair16({1'b0, mem_rdata[4]});
								dat_next = gp_reg[7];
							end
							8'b00??0001: begin
								cls_next = C_IMM16;
								tgt_next = {1'b0, mem_rdata[5:4]};
							end
							8'h2a: begin
								cls_next = C_IND16;
								tgt_next = 3'd2;
							end
							8'h36: begin
								cls_next = C_STN;
								adr_next = pair16(2'd2);
							end
							8'b01110???: begin
								cls_next = C_STREG;
								ok = mem_rdata[2:0] != 3'b110;
								adr_next = pair16(2'd2);
								src_next = mem_rdata[2:0];
								dat_next = gp_reg[mem_rdata[2:0]];
							end
							default: ok = 1'b0;
						endcase
						P_ED: casez (mem_rdata)
							`CLIU_OP_A_VEC, `CLIU_OP_A_REF, `CLIU_OP_VEC_A: cls_next = C_SPEC;
							8'b01??1011: begin
								cls_next = C_IND16;
								tgt_next = {1'b0, mem_rdata[5:4]};
							end
							default: ok = 1'b0;
						endcase
						default: begin
							tgt_next = {2'b10, pfx_reg[0]};
							casez (mem_rdata)
								8'h21: cls_next = C_IMM16;
								8'h2a: cls_next = C_IND16;
								8'h36: cls_next = C_STXN;
								8'b01110???: begin
									cls_next = C_STXR;
									ok = mem_rdata[2:0] != 3'b110;
									src_next = mem_rdata[2:0];
								end
								default: ok = 1'b0;
							endcase
						end
					endcase
					// Anything outside this unit's group stops the core
					if (!ok) begin
						ill_next = 1'b1;
						run_next = 1'b0;
						st_next = S_IDLE;
						pfx_next = P_NONE;
					end
				end
			end
			S_EXEC: if (tend) begin
				tc_next = 3'd0;
				case (kind)
					K_OPR: begin
						wd_next[3] = wd_reg[3] + 16'd1;
						case (cls_reg)
							C_IMM16, C_IND16: begin
								// Operand address or value arrives low byte first
								if (step_reg == 2'd0) adr_next[7:0] = mem_rdata;
								else adr_next[15:8] = mem_rdata;
								w16_en = cls_reg == C_IMM16 && step_reg == 2'd1;
								w16_val = {mem_rdata, adr_reg[7:0]};
							end
							C_STN: dat_next = mem_rdata;
							default: begin
								if (step_reg == 2'd0) begin
									// Signed displacement added to the selected index
									adr_next = wd_reg[tgt_reg[1:0] - 2'd3]
										+ {{8{mem_rdata[7]}}, mem_rdata};
									dat_next = gp_reg[src_reg];
								end else begin
									dat_next = mem_rdata;
								end
							end
						endcase
					end
					K_MRD: begin
						if (step_reg == 2'd2) begin
							dat_next = mem_rdata;
							adr_next = adr_reg + 16'd1;
						end else begin
							w16_en = 1'b1;
							w16_val = {mem_rdata, dat_reg};
						end
					end
					K_INT: if (cls_reg == C_SPEC) begin
						if (op_reg == `CLIU_OP_VEC_A) begin
							i_next = gp_reg[7];
						end else begin
							v = (op_reg == `CLIU_OP_A_VEC) ? i_reg : r_reg;
							flag_upd = 1'b1;
							gp_next[7] = v;
							gp_next[6][`CLIU_F_S] = v[7];
							gp_next[6][`CLIU_F_Z] = v == 8'h00;
							gp_next[6][`CLIU_F_H] = 1'b0;
							gp_next[6][`CLIU_F_PV] = iff_reg;
							gp_next[6][`CLIU_F_N] = 1'b0;
						end
					end
					default: ;
				endcase
				// 16-bit targets: pairs in the byte file, others in the word file
				if (w16_en) begin
					if (tgt_reg < 3'd3) {gp_next[{tgt_reg[1:0], 1'b0}], gp_next[{tgt_reg[1:0], 1'b1}]} = w16_val;
					else wd_next[tgt_reg[1:0] - 2'd3] = w16_val;
				end
				if (step_reg == last_step(cls_reg)) begin
					done = 1'b1;
					last_next = itc_reg + 5'd1;
					itc_next = 5'd0;
					pfx_next = P_NONE;
					st_next = run_reg ? S_FETCH : S_IDLE;
				end else begin
					step_next = step_reg + 2'd1;
				end
			end
			default: st_next = S_IDLE;
		endcase
		// Bus outputs for the machine cycle about to run
		sn = step_info(cls_next, step_next);
		kn = cliu_kind_t'(sn[4:3]);
		maddr_next = maddr_reg;
		mrd_next = 1'b0;
		mwr_next = 1'b0;
		mwd_next = mwd_reg;
		if (st_next == S_FETCH) begin
			maddr_next = wd_next[3];
			mrd_next = 1'b1;
		end else if (st_next == S_EXEC) begin
			maddr_next = (kn == K_OPR) ? wd_next[3] : adr_next;
			mrd_next = kn == K_OPR || kn == K_MRD;
			mwr_next = kn == K_WR;
			mwd_next = dat_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_reg <= S_IDLE;
			pfx_reg <= P_NONE;
			cls_reg <= C_SPEC;
			op_reg <= 8'h00;
			tgt_reg <= 3'd0;
			src_reg <= 3'd0;
			step_reg <= 2'd0;
			tc_reg <= 3'd0;
			adr_reg <= 16'h0000;
			dat_reg <= 8'h00;
			for (int k = 0; k < 8; k++) gp_reg[k] <= 8'h00;
			for (int k = 0; k < 3; k++) wd_reg[k] <= `CLIU_WORD_RST;
			wd_reg[3] <= `CLIU_PC_RST;
			i_reg <= 8'h00;
			r_reg <= 8'h00;
			iff_reg <= 1'b0;
			run_reg <= 1'b0;
			ill_reg <= 1'b0;
			itc_reg <= 5'd0;
			last_reg <= 5'd0;
			maddr_reg <= 16'h0000;
			mrd_reg <= 1'b0;
			mwr_reg <= 1'b0;
			mwd_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			pfx_reg <= pfx_next;
			cls_reg <= cls_next;
			op_reg <= op_next;
			tgt_reg <= tgt_next;
			src_reg <= src_next;
			step_reg <= step_next;
			tc_reg <= tc_next;
			adr_reg <= adr_next;
			dat_reg <= dat_next;
			gp_reg <= gp_next;
			wd_reg <= wd_next;
			i_reg <= i_next;
			r_reg <= r_next;
			iff_reg <= iff_next;
			run_reg <= run_next;
			ill_reg <= ill_next;
			itc_reg <= itc_next;
			last_reg <= last_next;
			maddr_reg <= maddr_next;
			mrd_reg <= mrd_next;
			mwr_reg <= mwr_next;
			mwd_reg <= mwd_next;
		end
	end

	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		awf_next = awf_reg;
		awa_next = awa_reg;
		wf_next = wf_reg;
		wdat_next = wdat_reg;
		wstb_next = wstb_reg;
		bv_next = bv_reg;
		bresp_next = bresp_reg;
		rv_next = rv_reg;
		rdat_next = rdat_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && awr_reg) begin
			awf_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_reg) begin
			wf_next = 1'b1;
			wdat_next = s_axi_wdata;
			wstb_next = s_axi_wstrb;
		end
		if (wfire) begin
			awf_next = 1'b0;
			wf_next = 1'b0;
			bv_next = 1'b1;
			bresp_next = map_hit(awa_reg) ? 2'b00 : 2'b10;
		end
		if (bv_reg && s_axi_bready) bv_next = 1'b0;
		if (rv_reg && s_axi_rready) rv_next = 1'b0;
		if (s_axi_arvalid && arr_reg) begin
			rv_next = 1'b1;
			rdat_next = rd_word(s_axi_araddr);
			rresp_next = map_hit(s_axi_araddr) ? 2'b00 : 2'b10;
		end
		awr_next = ~awf_next;
		wr_next = ~wf_next;
		arr_next = ~rv_next;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			awr_reg <= 1'b1;
			awf_reg <= 1'b0;
			awa_reg <= '0;
			wr_reg <= 1'b1;
			wf_reg <= 1'b0;
			wdat_reg <= 32'h0;
			wstb_reg <= 4'h0;
			bv_reg <= 1'b0;
			bresp_reg <= 2'b00;
			arr_reg <= 1'b1;
			rv_reg <= 1'b0;
			rdat_reg <= 32'h0;
			rresp_reg <= 2'b00;
		end else begin
			awr_reg <= awr_next;
			awf_reg <= awf_next;
			awa_reg <= awa_next;
			wr_reg <= wr_next;
			wf_reg <= wf_next;
			wdat_reg <= wdat_next;
			wstb_reg <= wstb_next;
			bv_reg <= bv_next;
			bresp_reg <= bresp_next;
			arr_reg <= arr_next;
			rv_reg <= rv_next;
			rdat_reg <= rdat_next;
			rresp_reg <= rresp_next;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready = awr_reg;
	assign s_axi_wready = wr_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rdat_reg;
	assign s_axi_rresp = rresp_reg;
	assign mem_addr = maddr_reg;
	assign mem_rd = mrd_reg;
	assign mem_wr = mwr_reg;
	assign mem_wdata = mwd_reg;

	// Checks on instruction timing and effects
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_LDAI_FLAGS: assert property (done && cls_reg == C_SPEC && op_reg == `CLIU_OP_A_VEC |=>
		gp_reg[7] == $past(i_reg) && gp_reg[6][7] == gp_reg[7][7] && gp_reg[6][6] == (gp_reg[7] == 8'h00)
		&& !gp_reg[6][4] && !gp_reg[6][1] && gp_reg[6][2] == $past(iff_reg)
		&& gp_reg[6][0] == $past(gp_reg[6][0])) else $error("vector page read result wrong");
	AST_LDAR_FLAGS: assert property (done && cls_reg == C_SPEC && op_reg == `CLIU_OP_A_REF |=>
		gp_reg[7] == $past(r_reg) && gp_reg[6][2] == $past(iff_reg) && !gp_reg[6][4]
		&& gp_reg[6][0] == $past(gp_reg[6][0])) else $error("refresh read result wrong");
	AST_SPEC_TIME: assert property (done && cls_reg == C_SPEC |-> itc_reg + 5'd1 == `CLIU_TOT_SPEC)
		else $error("special move not 9 states");
	AST_LDIA: assert property (done && cls_reg == C_SPEC && op_reg == `CLIU_OP_VEC_A |=>
		i_reg == $past(gp_reg[7]) && $stable(gp_reg[6])) else $error("vector page write wrong");
	AST_ST_ADDR: assert property (mwr_reg && cls_reg == C_STREG && !op_reg[6] |->
		maddr_reg == (op_reg[4] ? {gp_reg[2], gp_reg[3]} : {gp_reg[0], gp_reg[1]})
		&& mwd_reg == gp_reg[7]) else $error("pair store wrong");
	AST_ST_DATA: assert property (mwr_reg && cls_reg == C_STREG |-> mwd_reg == gp_reg[src_reg])
		else $error("register store data wrong");
	AST_ST_TIME: assert property (done && cls_reg == C_STREG |-> itc_reg + 5'd1 == `CLIU_TOT_ST)
		else $error("store not 7 states");
	AST_IMM_TIME: assert property (done && cls_reg == C_IMM16 |-> itc_reg + 5'd1 ==
		(pfx_reg == P_NONE ? `CLIU_TOT_IMM : `CLIU_TOT_IMMX)) else $error("immediate load time");
	AST_IND_TIME: assert property (done && cls_reg == C_IND16 |-> itc_reg + 5'd1 ==
		(pfx_reg == P_NONE ? `CLIU_TOT_LDHL : `CLIU_TOT_IND)) else $error("direct load time");
	AST_STN_TIME: assert property (done && cls_reg == C_STN |-> itc_reg + 5'd1 == `CLIU_TOT_IMM)
		else $error("immediate store time");
	AST_STX_TIME: assert property (done && (cls_reg == C_STXN || cls_reg == C_STXR) |->
		itc_reg + 5'd1 == `CLIU_TOT_STX) else $error("indexed store time");
	AST_FLAGS_KEPT: assert property (gp_reg[6] != $past(gp_reg[6]) |-> $past(flag_upd || wfire))
		else $error("flags changed by a plain move");

	COV_LDAI: cover property (done && cls_reg == C_SPEC && op_reg == `CLIU_OP_A_VEC);
	COV_IND_YIDX: cover property (done && cls_reg == C_IND16 && pfx_reg == P_IDXY);
	COV_STX: cover property (done && cls_reg == C_STXN);
	COV_ILL: cover property ($rose(ill_reg));
endmodule

// ---- verif/cliu_mem_model.sv ----
`timescale 1ns/1ps
// Byte memory on the core's bus; reads are combinational
module cliu_mem_model (
	// Memory bus
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic [7:0]       mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00;
	// Write on every write state; repeats carry the same byte
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			last_q <= mem[mem_addr];
		end
	end
	// Released bus shows inverted data so stale bytes cannot pass
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule

// ---- verif/test_cliu_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_cliu_top;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr;
	logic [1:0]  bresp, rresp, br, rr;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata, pfx;
	logic [7:0]  tab [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h50, 8'h00, 8'h00, 8'h99};
	int          err_total = 0, comparisons = 0, cyc = 0, t0 = -1, t1 = -1, endpc = 0, i, j;

	cliu_top cliu_top_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	cliu_mem_model cliu_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// 100 MHz clock
	initial forever #5 clk = ~clk;

	// Stamp the first fetch and the fetch after the instruction
	always @(posedge clk) begin
		cyc++;
		if (mem_rd && mem_addr == 16'h0100 && t0 < 0) t0 = cyc;
		if (mem_rd && mem_addr == endpc && t1 < 0) t1 = cyc;
	end

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		br = bresp;
		bready <= 1'b0;
		if (n == 50) begin err_total++; tally_and_finish(); end
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (n == 50) begin err_total++; tally_and_finish(); end
	endtask

	task automatic ck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		`CHK(rv & m, e)
	endtask

	// Run one instruction at 0100, stopped by a refused opcode after it
	task automatic go(input logic [31:0] code, input int len, input int st);
		int k;
		for (k = 0; k < len; k++) cliu_mem_model_i.mem[16'h0100 + k] = code[8*k +: 8];
		cliu_mem_model_i.mem[16'h0100 + len] = 8'h76;
		t0 = -1;
		t1 = -1;
		endpc = 16'h0100 + len;
		rv = 32'h0;
		wr(8'h24, 32'h0100);
		wr(8'h00, 32'h1);
		for (k = 0; k < 40 && rv[1] !== 1'b1; k++) rd(8'h04);
		if (rv[1] !== 1'b1) begin err_total++; tally_and_finish(); end
		// Clock states of the finished instruction as software sees them
		ck(8'h04, 32'h1f00_0000, 32'(st) << 24);
		wr(8'h04, 32'h2);
		`CHK(t1 - t0, st)
	endtask

	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wr(8'h28, 32'h0);
		wr(8'h08, 32'h8111);
		go(32'h47ed, 2, 9);
		ck(8'h28, 32'hff00, 32'h8100);
		ck(8'h08, 32'hffff, 32'h8111);
		go(32'h57ed, 2, 9);
		ck(8'h08, 32'hffff, 32'h8181);
		wr(8'h28, 32'h10000);
		wr(8'h08, 32'h0012);
		go(32'h57ed, 2, 9);
		ck(8'h08, 32'hffff, 32'h0044);
		wr(8'h28, 32'h100fe);
		wr(8'h08, 32'h0013);
		go(32'h5fed, 2, 9);
		ck(8'h08, 32'hffff, 32'h8085);
		wr(8'h08, 32'h7a00);
		wr(8'h0c, 32'h1212);
		wr(8'h10, 32'h1128);
		go(32'h02, 1, 7);
		`CHK(cliu_mem_model_i.mem[16'h1212], 8'h7a)
		ck(8'h08, 32'hffff, 32'h7a00);
		wr(8'h08, 32'ha000);
		go(32'h12, 1, 7);
		`CHK(cliu_mem_model_i.mem[16'h1128], 8'ha0)
		for (i = 0; i < 4; i++) go({8'h00, 8'h12, 8'h30 + 8'(i), 2'b00, i[1:0], 4'h1}, 3, 10);
		for (i = 0; i < 4; i++) ck(8'h0c + 8'(4*i), 32'hffff, {8'h12, 8'h30 + 8'(i)});
		for (i = 0; i < 4; i++) begin
			cliu_mem_model_i.mem[16'h4000 + 2*i] = 8'h65 + 8'(i);
			cliu_mem_model_i.mem[16'h4001 + 2*i] = 8'h78;
			go({8'h40, 8'(2*i), 2'b01, i[1:0], 4'hb, 8'hed}, 4, 20);
			ck(8'h0c + 8'(4*i), 32'hffff, {8'h78, 8'h65 + 8'(i)});
		end
		wr(8'h14, 32'h4444);
		go(32'h2836, 2, 10);
		`CHK(cliu_mem_model_i.mem[16'h4444], 8'h28)
		cliu_mem_model_i.mem[16'h4545] = 8'h37;
		cliu_mem_model_i.mem[16'h4546] = 8'ha1;
		go(32'h45452a, 3, 16);
		ck(8'h14, 32'hffff, 32'ha137);
		wr(8'h0c, 32'h1122);
		wr(8'h10, 32'h3344);
		wr(8'h14, 32'h5000);
		wr(8'h08, 32'h9900);
		for (i = 0; i < 8; i++) if (i != 6) begin
			go({24'h0, 5'b01110, i[2:0]}, 1, 7);
			`CHK(cliu_mem_model_i.mem[16'h5000], tab[i])
		end
		cliu_mem_model_i.mem[16'h6666] = 8'h92;
		cliu_mem_model_i.mem[16'h6667] = 8'hda;
		for (j = 0; j < 2; j++) begin
			pfx = j ? 8'hfd : 8'hdd;
			go({8'h45, 8'ha2 + 8'(j), 8'h21, pfx}, 4, 14);
			ck(8'h1c + 8'(4*j), 32'hffff, {8'h45, 8'ha2 + 8'(j)});
			go({8'h66, 8'h66, 8'h2a, pfx}, 4, 20);
			ck(8'h1c + 8'(4*j), 32'hffff, 32'hda92);
			wr(8'h1c + 8'(4*j), 32'h219a);
			go({8'h5a + 8'(j), 8'h05, 8'h36, pfx}, 4, 19);
			`CHK(cliu_mem_model_i.mem[16'h219f], 8'h5a + 8'(j))
			go({8'h5c + 8'(j), 8'hfe, 8'h36, pfx}, 4, 19);
			`CHK(cliu_mem_model_i.mem[16'h2198], 8'h5c + 8'(j))
			wr(8'h0c, 32'h001c + j);
			go({8'h00, 8'h80, 8'h71, pfx}, 3, 19);
			`CHK(cliu_mem_model_i.mem[16'h211a], 8'h1c + 8'(j))
		end
		// Unmapped offset and run bit cleared by the refused opcode
		wr(8'h3c, 32'h1);
		`CHK(br, 2'b10)
		rd(8'h3c);
		`CHK({rr, rv}, 34'h2_0000_0000)
		ck(8'h00, 32'h1, 32'h0);
		tally_and_finish();
	end
endmodule
